// [pkg/mfb_pkg.sv]
package mfb_pkg;

   // ----------------------------------------------------------------
   // map size and documented defaults
   // ----------------------------------------------------------------
   localparam int NUM_INPUTS = 40;
   localparam int NUM_COMP = 7;
   localparam logic [7:0] DEF_UNIT_ID = 8'h01;
   localparam logic [15:0] DEF_TCP_PORT = 16'h01f6;
   localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
   localparam logic [15:0] MAX_WRITE_REGS = 16'h007b;
   localparam logic [15:0] REG_PAIR_STEP = 16'h0002;

   // exception codes returned in a refused answer
   localparam logic [7:0] EXC_ILLEGAL_FUNCTION = 8'h01;
   localparam logic [7:0] EXC_ILLEGAL_ADDRESS = 8'h02;
   localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;

   // ----------------------------------------------------------------
   // quality checks
   // ----------------------------------------------------------------
   localparam logic [2:0] STALE_LIMIT = 3'h4;
   localparam logic [7:0] FLOAT_EXP_SPECIAL = 8'hff;
   localparam logic [7:0] FIX_EXP_ZERO = 8'h77;
   localparam logic [7:0] FIX_EXP_UNITY = 8'h8e;
   localparam logic [7:0] FIX_EXP_SAT = 8'h96;
   localparam logic [31:0] FIX_SAT_VALUE = 32'h00ff_ffff;
   localparam logic [31:0] COMP_SUM_LIMIT = 32'h0000_6400;

   // ----------------------------------------------------------------
   // input indices with behaviour of their own
   // ----------------------------------------------------------------
   localparam int IDX_ANALYSER_MW = 7;
   localparam int IDX_STEAM_T_RESERVED = 15;
   localparam int IDX_STEAM_P_RESERVED = 16;
   localparam int IDX_LOW_CF = 22;
   localparam int IDX_NORMAL_CF = 23;
   localparam int IDX_HIGH_CF = 24;
   localparam int IDX_UPDATE_INTERVAL = 25;
   localparam int IDX_LOW_BP = 26;
   localparam int IDX_NORMAL_BP = 27;
   localparam int IDX_HIGH_BP = 28;

   // zero-based register pair addresses, index order:
   // argon, carbon dioxide, carbon monoxide, hydrogen, nitrogen, oxygen, water vapour, analyser mw,
   // vent heating value, fuel flow, vent flow, vent temperature, vent pressure, vent sound speed,
   // steam flow, steam temperature reserved, steam pressure reserved, custom steam offset,
   // air flow, air temperature, air pressure, nitrogen flow, low/normal/high cf, update interval,
   // low/normal/high breakpoint, fuel min/max, tip and meter diameter, steam min/max,
   // air low/mid/high point, air min/max
   localparam logic [15:0] REG_ADDR [NUM_INPUTS] = '{
      16'h03f2, 16'h03f4, 16'h03f6, 16'h03f8, 16'h03fa, 16'h03fc, 16'h03fe, 16'h0406,
      16'h0408, 16'h0410, 16'h041a, 16'h041c, 16'h041e, 16'h0420, 16'h0424, 16'h0426,
      16'h0428, 16'h042a, 16'h042e, 16'h0430, 16'h0432, 16'h0434, 16'h0438, 16'h043a,
      16'h043c, 16'h0442, 16'h044c, 16'h044e, 16'h0450, 16'h046a, 16'h046c, 16'h0474,
      16'h0476, 16'h047e, 16'h0480, 16'h0488, 16'h048a, 16'h048c, 16'h0492, 16'h0494};

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] unit_id;
      logic [15:0] tcp_port;
      logic lsb_first;
      logic lsw_first;
   } mfb_cfg_type;

   typedef struct packed {
      logic [7:0] unit_id;
      logic [15:0] tcp_port;
      logic [7:0] func;
      logic [15:0] start;
      logic [15:0] count;
   } mfb_req_type;

   typedef struct packed {
      logic exception;
      logic [7:0] code;
      logic [7:0] func;
      logic [15:0] start;
      logic [15:0] count;
   } mfb_resp_type;

   typedef enum logic [1:0] {ST_IDLE, ST_DATA, ST_RESPOND} mfb_phase_type;

endpackage

// [hdl/mfb_register_bank.sv]
`timescale 1ns/100ps
// Notes on behaviour
// [R1] answer unit 1 on port 502 by default
// [R2] high byte of each register first
// [R3] high word at lower address first
// [R4] unit, port, byte and word order configurable
// [R5] every value is raw single-precision float
// [R6] decode listed addresses, no legacy ranges
// [R7] master writes only with function 16
// [R8] master sends even register count, minimum 2
// [R9] master starts every write at even address
// [R10] protocol address zero is first register
// [R11] one-based masters shift addresses by one
// [R12] bad on link loss, stuck or range
// [R13] bad input holds last good value
// [R14] composition over 100% marks all gases bad
// [R15] pair 1090 holds analyser update interval
// [R16] steam pairs 1062/1064 stored, unused
// [R17] breakpoints select matching correction factor
// [R18] odd address or count refused, nothing stored
module mfb_register_bank (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // configuration from the network settings
   input wire logic cfg_load,
   input wire mfb_pkg::mfb_cfg_type cfg_in,
   output mfb_pkg::mfb_cfg_type cfg_now,
   // request header from the tcp layer
   input wire logic req_valid,
   input wire mfb_pkg::mfb_req_type req_in,
   output logic req_ready,
   // register data words in arrival order
   input wire logic word_valid,
   input wire logic [15:0] word_data,
   output logic word_ready,
   // answer to the master
   output logic resp_valid,
   output mfb_pkg::mfb_resp_type resp_out,
   // link state and value readout
   input wire logic link_ok,
   input wire logic [5:0] rd_index,
   output logic [31:0] rd_value,
   output logic [39:0] quality_bad,
   output logic [31:0] mw_factor
);
   import mfb_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      mfb_phase_type st;
      mfb_cfg_type cfg;
      logic drop;
      logic store_en;
      logic half;
      logic [15:0] addr;
      logic [15:0] remain;
      logic [15:0] first_word;
      mfb_resp_type resp;
      logic [NUM_INPUTS-1:0][31:0] value;
      logic [NUM_INPUTS-1:0][31:0] last_good;
      logic [NUM_INPUTS-1:0][2:0] same_cnt;
      logic [NUM_INPUTS-1:0] bad;
      logic comp_over;
      logic [31:0] rd_value;
      logic [31:0] mw_factor;
   } mfb_state_type;

   mfb_state_type s;
   mfb_state_type next_s;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // listed pair addresses only; {hit, index}
   function automatic logic [6:0] addr_lookup(input logic [15:0] a);
      logic [6:0] res;
      res = '0;
      for (int i = 0; i < NUM_INPUTS; i++) begin
         if (a == REG_ADDR[i]) begin // [R6] [R10]
            res = {1'b1, 6'(i)};
         end
      end
      return res;
   endfunction

   // the value the plant logic must use for one input
   function automatic logic [31:0] held_value(input logic is_bad, input logic [31:0] v,
                                              input logic [31:0] good);
      return is_bad ? good : v; // [R13]
   endfunction

   // float percent to fixed point, 8 fraction bits; negative reads as zero
   function automatic logic [31:0] pct_fix(input logic [31:0] f);
      logic [7:0] e;
      logic [31:0] m;
      logic [31:0] r;
      e = f[30:23];
      m = {8'h00, 1'b1, f[22:0]};
      r = '0;
      if (f[31] || e < FIX_EXP_ZERO) begin
         r = '0;
      end else if (e >= FIX_EXP_SAT) begin
         r = FIX_SAT_VALUE;
      end else if (e >= FIX_EXP_UNITY) begin
         r = m << (e - FIX_EXP_UNITY);
      end else begin
         r = m >> (FIX_EXP_UNITY - e);
      end
      // clamping each gas keeps the seven-term sum inside 32 bits
      return (r > FIX_SAT_VALUE) ? FIX_SAT_VALUE : r;
   endfunction

   // register byte swap when the master sends low byte first
   function automatic logic [15:0] order_bytes(input logic lsb_first, input logic [15:0] w);
      return lsb_first ? {w[7:0], w[15:8]} : w; // [R2] [R4]
   endfunction

   // ----------------------------------------------------------------
   // handshakes
   // ----------------------------------------------------------------
   assign req_ready = (s.st == ST_IDLE);
   assign word_ready = (s.st == ST_DATA);
   assign resp_valid = (s.st == ST_RESPOND);
   assign resp_out = s.resp;
   assign cfg_now = s.cfg;
   assign rd_value = s.rd_value;
   assign quality_bad = s.bad;
   assign mw_factor = s.mw_factor;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [6:0] lk;
      logic [15:0] w;
      logic [31:0] f;
      logic [31:0] sum;
      logic [31:0] mw;
      lk = '0;
      w = '0;
      f = '0;
      sum = '0;
      mw = '0;
      next_s = s;
      // new settings take effect at once, even mid-request
      if (cfg_load) begin
         next_s.cfg = cfg_in; // [R4]
      end
      case (s.st)
         ST_IDLE: begin
            if (req_valid) begin
               // a request for another unit or port gets no answer at all
               next_s.drop = (req_in.unit_id != s.cfg.unit_id) || (req_in.tcp_port != s.cfg.tcp_port); // [R1]
               next_s.store_en = 1'b0;
               next_s.half = 1'b0;
               next_s.addr = req_in.start;
               next_s.remain = req_in.count;
               next_s.resp.func = req_in.func;
               next_s.resp.start = req_in.start;
               next_s.resp.count = req_in.count;
               next_s.resp.exception = 1'b0;
               next_s.resp.code = '0;
               lk = addr_lookup(req_in.start);
               if (req_in.func != FC_WRITE_MULTI) begin
                  // no data follows any other function
                  next_s.resp.exception = 1'b1; // [R7]
                  next_s.resp.code = EXC_ILLEGAL_FUNCTION;
                  next_s.remain = '0;
                  next_s.st = next_s.drop ? ST_IDLE : ST_RESPOND;
               end else begin
                  if (req_in.start[0] || req_in.count[0]) begin
                     next_s.resp.exception = 1'b1; // [R18] [R8] [R9]
                     next_s.resp.code = EXC_ILLEGAL_ADDRESS;
                  end else if (req_in.count == '0 || req_in.count > MAX_WRITE_REGS) begin
                     next_s.resp.exception = 1'b1; // [R8]
                     next_s.resp.code = EXC_ILLEGAL_VALUE;
                  end else if (!lk[6]) begin
                     next_s.resp.exception = 1'b1; // [R6]
                     next_s.resp.code = EXC_ILLEGAL_ADDRESS;
                  end else begin
                     next_s.store_en = !next_s.drop;
                  end
                  if (req_in.count == '0) begin
                     next_s.st = next_s.drop ? ST_IDLE : ST_RESPOND;
                  end else begin
                     next_s.st = ST_DATA;
                  end
               end
            end
         end
         ST_DATA: begin
            // refused writes still drain their words so the stream stays aligned
            if (word_valid) begin
               w = order_bytes(s.cfg.lsb_first, word_data);
               if (!s.half) begin
                  next_s.first_word = w;
                  next_s.half = 1'b1;
               end else begin
                  next_s.half = 1'b0;
                  f = s.cfg.lsw_first ? {w, s.first_word} : {s.first_word, w}; // [R3] [R4] [R5]
                  lk = addr_lookup(s.addr);
                  // gaps between listed pairs are skipped without effect
                  if (s.store_en && lk[6]) begin
                     if (s.value[lk[5:0]] == f) begin
                        if (s.same_cnt[lk[5:0]] != STALE_LIMIT) begin
                           next_s.same_cnt[lk[5:0]] = s.same_cnt[lk[5:0]] + 3'h1; // [R12]
                        end
                     end else begin
                        next_s.same_cnt[lk[5:0]] = '0;
                     end
                     // reserved steam pairs and the interval are kept only for readback
                     next_s.value[lk[5:0]] = f; // [R15] [R16]
                  end
                  next_s.addr = s.addr + REG_PAIR_STEP;
               end
               next_s.remain = s.remain - 16'h0001;
               if (s.remain == 16'h0001) begin
                  next_s.st = s.drop ? ST_IDLE : ST_RESPOND;
               end
            end
         end
         ST_RESPOND: begin
            next_s.st = ST_IDLE;
         end
         default: begin
            next_s.st = ST_IDLE;
         end
      endcase

      // composition plausibility on the values as they will stand
      for (int i = 0; i < NUM_COMP; i++) begin
         sum = sum + pct_fix(next_s.value[i]);
      end
      next_s.comp_over = (sum > COMP_SUM_LIMIT); // [R14]

      // quality per input, then capture only good values as last good
      for (int i = 0; i < NUM_INPUTS; i++) begin
         next_s.bad[i] = !link_ok
                         || (next_s.same_cnt[i] >= STALE_LIMIT)
                         || (next_s.value[i][30:23] == FLOAT_EXP_SPECIAL)
                         || ((i < NUM_COMP) && next_s.comp_over); // [R12] [R14]
         if (!next_s.bad[i]) begin
            next_s.last_good[i] = next_s.value[i]; // [R13]
         end
      end

      // readout always shows the value in use, not the raw write
      if (rd_index < 6'(NUM_INPUTS)) begin
         next_s.rd_value = held_value(next_s.bad[rd_index], next_s.value[rd_index],
                                      next_s.last_good[rd_index]); // [R13]
      end else begin
         next_s.rd_value = '0;
      end

      // positive floats order like unsigned integers, so no float compare is needed
      mw = held_value(next_s.bad[IDX_ANALYSER_MW], next_s.value[IDX_ANALYSER_MW],
                      next_s.last_good[IDX_ANALYSER_MW]);
      if (mw[31] || mw <= next_s.value[IDX_LOW_BP]) begin
         next_s.mw_factor = next_s.value[IDX_LOW_CF]; // [R17]
      end else if (mw >= next_s.value[IDX_HIGH_BP]) begin
         next_s.mw_factor = next_s.value[IDX_HIGH_CF]; // [R17]
      end else begin
         next_s.mw_factor = next_s.value[IDX_NORMAL_CF]; // [R17]
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   // values clear to zero on reset; nothing survives a restart
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         s <= '0;
         s.st <= ST_IDLE;
         s.cfg.unit_id <= DEF_UNIT_ID; // [R1]
         s.cfg.tcp_port <= DEF_TCP_PORT; // [R1]
         s.cfg.lsb_first <= 1'b0; // [R2]
         s.cfg.lsw_first <= 1'b0; // [R3]
         s.bad <= '1;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_take_other_func;
      req_valid && req_ready && req_in.func != FC_WRITE_MULTI
      && req_in.unit_id == s.cfg.unit_id && req_in.tcp_port == s.cfg.tcp_port;
   endsequence

   sequence s_last_word;
      s.st == ST_DATA && word_valid && s.remain == 16'h0001 && !s.drop;
   endsequence

   sequence s_odd_write;
      req_valid && req_ready && req_in.func == FC_WRITE_MULTI && (req_in.start[0] || req_in.count[0])
      && req_in.count != '0;
   endsequence

   a_illegal_func: assert property (@(posedge ref_clk) disable iff (reset) // [R7]
      s_take_other_func |=> resp_valid && resp_out.exception && resp_out.code == EXC_ILLEGAL_FUNCTION)
      else $error("other function code not refused in one cycle");

   a_odd_refused: assert property (@(posedge ref_clk) disable iff (reset) // [R18]
      s_odd_write |=> (!s.store_en && s.resp.exception && s.resp.code == EXC_ILLEGAL_ADDRESS))
      else $error("odd write not marked for refusal");

   a_refused_stable: assert property (@(posedge ref_clk) disable iff (reset) // [R18]
      (s.st == ST_DATA && !s.store_en) |=> $stable(s.value))
      else $error("refused write changed stored values");

   a_answer_done: assert property (@(posedge ref_clk) disable iff (reset) // [R1]
      s_last_word |=> resp_valid ##1 !resp_valid && req_ready)
      else $error("no single answer after last word");

   a_drop_silent: assert property (@(posedge ref_clk) disable iff (reset) // [R1]
      (s.st == ST_DATA && s.drop) |-> !s.store_en)
      else $error("foreign request allowed to store");

   a_hold_last: assert property (@(posedge ref_clk) disable iff (reset) // [R13]
      s.bad[IDX_ANALYSER_MW] |-> $stable(s.last_good[IDX_ANALYSER_MW]))
      else $error("last good value moved while input bad");

   a_comp_sum: assert property (@(posedge ref_clk) disable iff (reset) // [R14]
      s.comp_over |-> &s.bad[NUM_COMP-1:0])
      else $error("gas left good while total over limit");

   a_link_lost: assert property (@(posedge ref_clk) disable iff (reset) // [R12]
      !link_ok |=> &s.bad)
      else $error("input good while link lost");

   a_unit_default: assert property (@(posedge ref_clk) // [R1]
      $fell(reset) && !cfg_load |-> s.cfg.unit_id == DEF_UNIT_ID && s.cfg.tcp_port == DEF_TCP_PORT)
      else $error("defaults not loaded at reset");

   a_factor_high: assert property (@(posedge ref_clk) disable iff (reset) // [R17]
      (!s.bad[IDX_ANALYSER_MW] && !s.value[IDX_ANALYSER_MW][31]
       && s.value[IDX_ANALYSER_MW] > s.value[IDX_LOW_BP]
       && s.value[IDX_ANALYSER_MW] >= s.value[IDX_HIGH_BP]) |-> mw_factor == s.value[IDX_HIGH_CF])
      else $error("high factor not selected above high breakpoint");

endmodule

// [bench/mfb_master_model.sv]
`timescale 1ns/100ps
module mfb_master_model (
   // clock
   input wire logic ref_clk,
   // header and data toward the bank
   output logic req_valid,
   output mfb_pkg::mfb_req_type req_in,
   input wire logic req_ready,
   output logic word_valid,
   output logic [15:0] word_data,
   input wire logic word_ready,
   // answer from the bank
   input wire logic resp_valid,
   input wire mfb_pkg::mfb_resp_type resp_in
);
   import mfb_pkg::*;

   // ----------------------------------------------------------------
   // idle levels
   // ----------------------------------------------------------------
   initial begin
      req_valid = 1'b0;
      req_in = '0;
      word_valid = 1'b0;
      word_data = 16'h0000;
   end

   // ----------------------------------------------------------------
   // one whole request; header held until taken, each word until taken
   // ----------------------------------------------------------------
   // addresses go out zero-based, exactly as given by the caller
   task automatic transfer(input mfb_req_type hdr, input logic [15:0] words [$], output logic got,
                           output mfb_resp_type resp);
      int n;
      got = 1'b0;
      resp = '0;
      req_valid <= 1'b1;
      req_in <= hdr;
      @(negedge ref_clk);
      for (n = 0; n < 20 && req_ready !== 1'b1; n++) begin
         @(negedge ref_clk);
      end
      @(posedge ref_clk);
      req_valid <= 1'b0;
      req_in <= ~hdr; // a released header must not look like the old one
      // words leave in caller order, as many as given; the caller decides pairing and which half goes first
      foreach (words[i]) begin
         word_valid <= 1'b1;
         word_data <= words[i];
         @(negedge ref_clk);
         for (n = 0; n < 20 && word_ready !== 1'b1; n++) begin
            @(negedge ref_clk);
         end
         @(posedge ref_clk);
      end
      word_valid <= 1'b0;
      if (words.size() > 0) begin
         word_data <= ~words[words.size() - 1];
      end
      // ready and answer only move on rising edges, so both are read on falling ones
      for (n = 0; n < 8 && !got; n++) begin
         @(negedge ref_clk);
         if (resp_valid === 1'b1) begin
            got = 1'b1;
            resp = resp_in;
         end
      end
      @(posedge ref_clk);
   endtask
endmodule

// [bench/tb.sv]
`timescale 1ns/100ps
module tb;
   import mfb_pkg::*;

   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic ref_clk, reset, cfg_load, link_ok, req_valid, req_ready, word_valid, word_ready, resp_valid;
   mfb_cfg_type cfg_in, cfg_now;
   mfb_req_type req_in;
   mfb_resp_type resp_out;
   logic [15:0] word_data;
   logic [5:0] rd_index;
   logic [31:0] rd_value, mw_factor;
   logic [39:0] quality_bad;
   logic [7:0] cur_unit = 8'h01;
   logic [15:0] cur_port = 16'h01f6;
   int n_errors = 0;
   int comparisons = 0;

   mfb_register_bank uut (.ref_clk(ref_clk), .reset(reset), .cfg_load(cfg_load), .cfg_in(cfg_in),
      .cfg_now(cfg_now), .req_valid(req_valid), .req_in(req_in), .req_ready(req_ready),
      .word_valid(word_valid), .word_data(word_data), .word_ready(word_ready), .resp_valid(resp_valid),
      .resp_out(resp_out), .link_ok(link_ok), .rd_index(rd_index), .rd_value(rd_value),
      .quality_bad(quality_bad), .mw_factor(mw_factor));
   mfb_master_model master (.ref_clk(ref_clk), .req_valid(req_valid), .req_in(req_in),
      .req_ready(req_ready), .word_valid(word_valid), .word_data(word_data), .word_ready(word_ready),
      .resp_valid(resp_valid), .resp_in(resp_out));

   // ----------------------------------------------------------------
   // checking and closing
   // ----------------------------------------------------------------
   task automatic compare_val(input string what, input logic [39:0] e, input logic [39:0] s);
      comparisons++;
      if (s !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, e, s);
      end
   endtask

   // refusals are judged on flag and code only, accepted writes on the echo
   task automatic compare_resp(input string what, input mfb_resp_type e, input mfb_resp_type s);
      comparisons++;
      if (s.exception !== e.exception || (e.exception && s.code !== e.code) ||
          (!e.exception && (s.start !== e.start || s.count !== e.count))) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, e, s);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic mfb_req_type hdr(input logic [7:0] f, input logic [15:0] s, input logic [15:0] c);
      return '{cur_unit, cur_port, f, s, c};
   endfunction

   task automatic settle;
      repeat (3) @(posedge ref_clk);
   endtask

   task automatic wr(input logic [15:0] start, input logic [31:0] vals [$]);
      logic [15:0] w [$];
      logic got;
      mfb_resp_type r;
      foreach (vals[i]) begin
         w.push_back(vals[i][31:16]);
         w.push_back(vals[i][15:0]);
      end
      master.transfer(hdr(FC_WRITE_MULTI, start, 16'(w.size())), w, got, r);
      compare_val("write answered", 40'h1, {39'h0, got});
      compare_resp("write answer", '{1'b0, 8'h00, FC_WRITE_MULTI, start, 16'(w.size())}, r);
      settle();
   endtask

   task automatic rd_check(input logic [5:0] idx, input logic [31:0] e);
      rd_index <= idx;
      settle();
      compare_val("rd_value", {8'h00, e}, {8'h00, rd_value});
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_defaults;
      compare_val("cfg_now", 40'(27'h00407d8), 40'(cfg_now));
      compare_val("quality_bad", 40'h0, quality_bad);
   endtask

   task automatic t_order;
      wr(16'h03f2, {32'h40490fdb});
      rd_check(6'd0, 32'h40490fdb);
      wr(16'h03f2, {32'h3f000000, 32'h3dcccccd});
      rd_check(6'd0, 32'h3f000000);
      rd_check(6'd1, 32'h3dcccccd);
   endtask

   task automatic t_refused;
      logic [15:0] st [7] = '{16'h03f3, 16'h03f2, 16'h03f2, 16'h03f2, 16'h9c40, 16'h0000, 16'h03f2};
      logic [15:0] ct [7] = '{16'h0002, 16'h0003, 16'h0000, 16'h0002, 16'h0002, 16'h0002, 16'h007c};
      logic [7:0] fc [7] = '{8'h10, 8'h10, 8'h10, 8'h03, 8'h10, 8'h10, 8'h10};
      logic [7:0] ex [7] = '{8'h02, 8'h02, 8'h03, 8'h01, 8'h02, 8'h02, 8'h03};
      logic [15:0] w [$];
      logic got;
      mfb_resp_type r;
      for (int k = 0; k < 7; k++) begin
         w = {};
         for (int j = 0; fc[k] == FC_WRITE_MULTI && j < int'(ct[k]); j++) begin
            w.push_back(16'(16'h5a00 + j));
         end
         master.transfer(hdr(fc[k], st[k], ct[k]), w, got, r);
         compare_resp("refused answer", '{1'b1, ex[k], fc[k], st[k], ct[k]}, r);
      end
      rd_check(6'd0, 32'h3f000000);
   endtask

   task automatic t_config;
      logic got;
      mfb_resp_type r;
      cfg_in <= '{8'h05, 16'h1234, 1'b1, 1'b1};
      cfg_load <= 1'b1;
      @(posedge ref_clk);
      cfg_load <= 1'b0;
      settle();
      compare_val("cfg_now", 40'(27'h01448d3), 40'(cfg_now));
      master.transfer(hdr(FC_WRITE_MULTI, 16'h03f4, 16'h0002), {16'h0102, 16'h0304}, got, r);
      compare_val("foreign unit answered", 40'h0, {39'h0, got});
      cur_unit = 8'h05;
      cur_port = 16'h1234;
      master.transfer(hdr(FC_WRITE_MULTI, 16'h03f4, 16'h0002), {16'h4433, 16'h2211}, got, r);
      rd_check(6'd1, 32'h11223344);
      cfg_in <= '{8'h01, 16'h01f6, 1'b0, 1'b0};
      cfg_load <= 1'b1;
      @(posedge ref_clk);
      cfg_load <= 1'b0;
      cur_unit = 8'h01;
      cur_port = 16'h01f6;
      settle();
   endtask

   task automatic t_quality;
      wr(16'h041a, {32'h41740000});
      wr(16'h041a, {32'h7fc00000});
      compare_val("nan flagged", 40'h1, {39'h0, quality_bad[10]});
      rd_check(6'd10, 32'h41740000);
      wr(16'h041a, {32'h41750000});
      link_ok <= 1'b0;
      settle();
      compare_val("link lost", 40'hff_ffff_ffff, quality_bad);
      link_ok <= 1'b1;
      settle();
      compare_val("link back", 40'h0, quality_bad);
      repeat (4) wr(16'h041c, {32'h42010000});
      compare_val("three repeats", 40'h0, {39'h0, quality_bad[11]});
      wr(16'h041c, {32'h42010000});
      compare_val("stuck value", 40'h1, {39'h0, quality_bad[11]});
      wr(16'h041c, {32'h42020000});
      compare_val("moving again", 40'h0, {39'h0, quality_bad[11]});
      rd_check(6'd11, 32'h42020000);
   endtask

   // 125 percent must trip every gas; exactly 100 percent must not
   task automatic t_gas;
      wr(16'h03f2, {32'h42700000, 32'h42480000, 32'h3f800000, 32'h40000000, 32'h40400000,
                    32'h40800000, 32'h40a00000});
      compare_val("gas sum over", 40'h7f, {33'h0, quality_bad[6:0]});
      compare_val("others good", 40'h0, {7'h0, quality_bad[39:7]});
      wr(16'h03f4, {32'h41c80000});
      compare_val("gas sum at limit", 40'h0, {33'h0, quality_bad[6:0]});
   endtask

   task automatic t_weight;
      wr(16'h0438, {32'h3fc00000, 32'h40200000, 32'h40600000});
      wr(16'h044c, {32'h41a00000, 32'h41f00000, 32'h42200000});
      wr(16'h0406, {32'h41200000});
      compare_val("low factor", 40'h3fc00000, {8'h00, mw_factor});
      wr(16'h0406, {32'h41f00000});
      compare_val("normal factor", 40'h40200000, {8'h00, mw_factor});
      wr(16'h0406, {32'h42200000});
      compare_val("high factor", 40'h40600000, {8'h00, mw_factor});
      wr(16'h0442, {32'h40a00000});
      rd_check(6'd25, 32'h40a00000);
      wr(16'h0426, {32'h42c80000, 32'h41100000});
      rd_check(6'd15, 32'h42c80000);
      rd_check(6'd16, 32'h41100000);
      compare_val("factor untouched", 40'h40600000, {8'h00, mw_factor});
   endtask

   // ----------------------------------------------------------------
   // clock, reset, sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   initial begin
      reset = 1'b1;
      cfg_load = 1'b0;
      cfg_in = '{8'h01, 16'h01f6, 1'b0, 1'b0};
      link_ok = 1'b1;
      rd_index = 6'd0;
      repeat (20) @(posedge ref_clk);
      reset <= 1'b0;
      settle();
      t_defaults();
      t_order();
      t_refused();
      t_config();
      t_quality();
      t_gas();
      t_weight();
      tally_and_finish();
   end

   // the whole sequence needs a few hundred cycles; 10000 means a hang
   initial begin
      #500000;
      n_errors++;
      tally_and_finish();
   end
endmodule
